//--- pot_pkg.sv
// Shared constants for the dual potentiometer two-wire link
package pot_pkg;
	// Clock rate
	localparam int CLK_MHZ = 25;
	// Device type nibble of the slave address (value arbitrary)
	localparam logic [3:0] DEV_TYPE = 4'ha;
	// Opcodes in the instruction byte
	localparam logic [3:0] OP_RD_WIPER  = 4'h9;
	localparam logic [3:0] OP_WR_WIPER  = 4'ha;
	localparam logic [3:0] OP_RD_SET    = 4'hb;
	localparam logic [3:0] OP_WR_SET    = 4'hc;
	localparam logic [3:0] OP_SET2WIP   = 4'hd;
	localparam logic [3:0] OP_WIP2SET   = 4'he;
	localparam logic [3:0] OP_GSET2WIP  = 4'h1;
	localparam logic [3:0] OP_GWIP2SET  = 4'h8;
	localparam logic [3:0] OP_INCDEC    = 4'h2;
	// Instruction byte fields
	localparam int INS_OP_LSB   = 4;
	localparam int INS_BANK_LSB = 2;
	localparam int INS_ZERO_BIT = 1;
	localparam int INS_POT_BIT  = 0;
	// Wiper values
	localparam logic [5:0] TAP_MAX       = 6'h3f;
	localparam logic [5:0] SETTING_RESET = 6'h00;
	// Wiper settle delay
	localparam int WIPER_SETTLE_NS = 10000;
	localparam int SETTLE_CYCLES   = (WIPER_SETTLE_NS * CLK_MHZ + 999) / 1000;
	// Nonvolatile write time
	localparam int NV_WRITE_US     = 5000;
	localparam int NV_WRITE_CYCLES = NV_WRITE_US * CLK_MHZ;
	// Controller register map
	localparam logic [11:0] CMD_OFS  = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	// Command fields
	localparam int CMD_START = 8;
	localparam int CMD_STOP  = 9;
	localparam int CMD_READ  = 10;
	localparam int CMD_MACK  = 11;
	localparam int CMD_STEP  = 12;
	localparam int CMD_SKIP  = 13;
	// Status fields
	localparam int STAT_BUSY = 8;
	localparam int STAT_NACK = 9;
	// Serial clock half period in clock cycles
	localparam int SCL_HALF = 8;
endpackage

//--- pot_link_if.sv
// Two-wire link between controller and potentiometer device
interface pot_link_if;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic sda;
	// Open-drain wire with pull-up
	assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));
	modport host (output scl, output sda_m_o, output sda_m_oe, input sda);
	modport dev (input scl, output sda_d_o, output sda_d_oe, input sda);
endinterface

//--- pot_device.sv
// Two-wire slave front end of the dual potentiometer
// Overview of operation
// R01 - Low write protect refuses nonvolatile writes
// R02 - Data changes only while clock low
// R03 - Wait for start before any response
// R04 - Master ends each communication with stop
// R05 - Receiver drives ninth-clock acknowledge low
// R06 - Acknowledge address, instruction and data byte
// R07 - Upper address nibble must match type
// R08 - Lower address nibble must match straps
// R09 - Stop after nonvolatile command starts write
// R10 - No address acknowledge while write busy
// R11 - Instruction: opcode, bank, zero, pot
// R12 - Four two-byte copy instructions
// R13 - Setting to wiper shows after settle
// R14 - Wiper to setting takes write time
// R15 - Copies single pot or both pots
// R16 - Four three-byte read/write instructions
// R17 - Clock with data high steps up
// R18 - Clock with data low steps down
// R19 - One tap switch on per pot
// R20 - Master makes clock and starts transfers
// R21 - Opcode encodings for the nine instructions
// R22 - Power-up loads wiper from setting zero
// R23 - Nonvolatile change ends within 10 ms
// R24 - Stepping saturates and ends at stop
module pot_device import pot_pkg::*; #(
	parameter int         NV_CYCLES = NV_WRITE_CYCLES,
	parameter logic [3:0] TYPE_ID   = DEV_TYPE
) (
	// Clock, reset, enable
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	// Straps and protection
	input  wire logic [3:0]  BOARD_SEL,
	input  wire logic        WP_N,
	// Two-wire link
	pot_link_if.dev          link,
	// Wiper tap selects and write status
	output logic      [63:0] WIPER0_TAPS,
	output logic      [63:0] WIPER1_TAPS,
	output logic             BUSY
);
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_ADDR  = 4'b0001,
		ST_INSTR = 4'b0011,
		ST_WDATA = 4'b0010,
		ST_ACK   = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RACK  = 4'b0101,
		ST_INCDC = 4'b0100,
		ST_HOLD  = 4'b1100
	} dstate_t;

	dstate_t     state_q, nxt_q;
	logic [2:0]  scl_s_q, sda_s_q;
	logic [3:0]  sel_m_q, sel_q;
	logic        wp_m_q, wp_q;
	logic [3:0]  cnt_q;
	logic [7:0]  shreg_q;
	logic        ack_q, boot_q, sda_oe_q;
	logic [3:0]  op_q;
	logic [1:0]  bank_q;
	logic        pot_q;
	logic        nv_pend_q, nv_glob_q, nv_pot_q, busy_q;
	logic [1:0]  nv_bank_q;
	logic [5:0]  nv_val_q [2];
	logic [5:0]  wiper_q [2];
	logic [5:0]  shown_q [2];
	logic [5:0]  setting_q [2][4];
	logic [63:0] taps_q [2];
	logic [23:0] nv_cnt_q;
	logic [15:0] settle_q;
	logic        scl_rise, scl_fall, start_ev, stop_ev;
	logic        byte_end, addr_ok, ins_ok, settle_go;
	logic [3:0]  op_in;
	logic        pot_in;
	logic [1:0]  bank_in;

	// Two-stage sync of pins, third stage for edges
	always_ff @(posedge CLK) begin
		if (RST) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			sel_m_q <= 4'h0;
			sel_q   <= 4'h0;
			wp_m_q  <= 1'b0;
			wp_q    <= 1'b0;
		end else if (CE) begin
			scl_s_q <= {scl_s_q[1:0], link.scl};
			sda_s_q <= {sda_s_q[1:0], link.sda};
			sel_m_q <= BOARD_SEL;
			sel_q   <= sel_m_q;
			wp_m_q  <= WP_N;
			wp_q    <= wp_m_q;
		end
	end

	// Bus events; data moves only with clock low
	assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
	assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
	assign start_ev = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2]; // R02 R03
	assign stop_ev  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2]; // R02 R04
	assign byte_end = scl_fall & (cnt_q == 4'h8);

	// Address and instruction checks
	assign addr_ok = (shreg_q[7:4] == TYPE_ID) // R07
		& (shreg_q[3:0] == sel_q) & ~busy_q; // R08 R10
	assign op_in   = shreg_q[7:INS_OP_LSB]; // R11
	assign bank_in = shreg_q[INS_BANK_LSB +: 2];
	assign pot_in  = shreg_q[INS_POT_BIT];
	always_comb begin
		case (op_in) // R21
			OP_RD_WIPER, OP_WR_WIPER, OP_RD_SET, OP_WR_SET,
			OP_SET2WIP, OP_WIP2SET, OP_GSET2WIP, OP_GWIP2SET,
			OP_INCDEC: ins_ok = ~shreg_q[INS_ZERO_BIT]; // R11
			default:   ins_ok = 1'b0;
		endcase
	end
	assign settle_go = (state_q == ST_INSTR) & byte_end & ins_ok
		& ((op_in == OP_SET2WIP) | (op_in == OP_GSET2WIP)); // R13

	// Protocol engine and wiper registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q   <= ST_IDLE;
			nxt_q     <= ST_IDLE;
			cnt_q     <= 4'h0;
			shreg_q   <= 8'h00;
			ack_q     <= 1'b0;
			boot_q    <= 1'b1;
			op_q      <= 4'h0;
			bank_q    <= 2'h0;
			pot_q     <= 1'b0;
			nv_pend_q <= 1'b0;
			nv_glob_q <= 1'b0;
			nv_pot_q  <= 1'b0;
			nv_bank_q <= 2'h0;
			for (int p = 0; p < 2; p++) begin
				wiper_q[p]  <= SETTING_RESET;
				nv_val_q[p] <= SETTING_RESET;
			end
		end else if (CE) begin
			if (boot_q) begin
				boot_q <= 1'b0;
				for (int p = 0; p < 2; p++)
					wiper_q[p] <= setting_q[p][0]; // R22
			end
			if (start_ev) begin
				state_q <= ST_ADDR; // R03
				cnt_q   <= 4'h0;
			end else if (stop_ev) begin
				state_q   <= ST_IDLE; // R24
				nv_pend_q <= 1'b0;
			end else begin
				case (state_q)
				ST_ADDR, ST_INSTR, ST_WDATA: begin
					if (scl_rise && cnt_q < 4'h8) begin
						shreg_q <= {shreg_q[6:0], sda_s_q[1]};
						cnt_q   <= cnt_q + 4'h1;
					end else if (byte_end) begin
						state_q <= ST_ACK; // R05
						if (state_q == ST_ADDR) begin
							ack_q <= addr_ok; // R06
							nxt_q <= addr_ok ? ST_INSTR : ST_IDLE;
						end else if (state_q == ST_INSTR) begin
							ack_q  <= ins_ok; // R06
							op_q   <= op_in;
							bank_q <= bank_in;
							pot_q  <= pot_in;
							nxt_q  <= ST_IDLE;
							if (ins_ok) begin
								case (op_in)
								OP_RD_WIPER, OP_RD_SET: begin
									nxt_q <= ST_RDATA; // R16
								end
								OP_WR_WIPER, OP_WR_SET: begin
									nxt_q <= ST_WDATA; // R16
								end
								OP_INCDEC: begin
									nxt_q <= ST_INCDC;
								end
								OP_SET2WIP: begin
									wiper_q[pot_in] <= setting_q[pot_in][bank_in]; // R12
									nxt_q <= ST_HOLD;
								end
								OP_GSET2WIP: begin
									for (int p = 0; p < 2; p++)
										wiper_q[p] <= setting_q[p][bank_in]; // R15
									nxt_q <= ST_HOLD;
								end
								OP_WIP2SET, OP_GWIP2SET: begin
									nv_pend_q <= 1'b1; // R12 R15
									nv_glob_q <= (op_in == OP_GWIP2SET);
									nv_pot_q  <= pot_in;
									nv_bank_q <= bank_in;
									nv_val_q[0] <= wiper_q[0];
									nv_val_q[1] <= wiper_q[1];
									nxt_q <= ST_HOLD;
								end
								default: nxt_q <= ST_IDLE;
								endcase
							end
						end else begin
							ack_q <= 1'b1; // R06
							nxt_q <= ST_HOLD;
							if (op_q == OP_WR_WIPER) begin
								wiper_q[pot_q] <= shreg_q[5:0]; // R16
							end else begin
								nv_pend_q <= 1'b1; // R16
								nv_glob_q <= 1'b0;
								nv_pot_q  <= pot_q;
								nv_bank_q <= bank_q;
								nv_val_q[pot_q] <= shreg_q[5:0];
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						state_q <= nxt_q;
						cnt_q   <= 4'h0;
						if (nxt_q == ST_RDATA)
							shreg_q <= {2'b00, (op_q == OP_RD_WIPER) ?
								wiper_q[pot_q] : setting_q[pot_q][bank_q]};
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (cnt_q == 4'h7) begin
							state_q <= ST_RACK; // R05
						end else begin
							shreg_q <= {shreg_q[6:0], 1'b0};
							cnt_q   <= cnt_q + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_fall)
						state_q <= ST_HOLD;
				end
				ST_INCDC: begin
					if (scl_rise) begin
						shreg_q[0] <= sda_s_q[1]; // Level held for pulse
						cnt_q      <= 4'h1;
					end else if (scl_fall && cnt_q != 4'h0) begin
						cnt_q <= 4'h0; // Stop pulse never lands
						if (shreg_q[0] && wiper_q[pot_q] != TAP_MAX)
							wiper_q[pot_q] <= wiper_q[pot_q] + 6'h01; // R17 R24
						else if (!shreg_q[0] && wiper_q[pot_q] != 6'h00)
							wiper_q[pot_q] <= wiper_q[pot_q] - 6'h01; // R18 R24
					end
				end
				ST_IDLE, ST_HOLD: ;
				default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Open-drain data drive: acknowledge or read bit
	always_ff @(posedge CLK) begin
		if (RST)
			sda_oe_q <= 1'b0;
		else if (CE)
			sda_oe_q <= ((state_q == ST_ACK) & ack_q) // R05
				| ((state_q == ST_RDATA) & ~shreg_q[7]);
	end
	assign link.sda_d_o  = 1'b0;
	assign link.sda_d_oe = sda_oe_q;

	// Nonvolatile write cycle launched by stop
	always_ff @(posedge CLK) begin
		if (RST) begin
			busy_q   <= 1'b0;
			nv_cnt_q <= 24'h000000;
			for (int p = 0; p < 2; p++)
				for (int b = 0; b < 4; b++)
					setting_q[p][b] <= SETTING_RESET;
		end else if (CE) begin
			if (stop_ev && nv_pend_q && wp_q && !busy_q) begin
				busy_q   <= 1'b1; // R01 R09
				nv_cnt_q <= 24'(NV_CYCLES - 1);
			end else if (busy_q) begin
				if (nv_cnt_q == 24'h000000) begin
					busy_q <= 1'b0; // R14 R23
					for (int p = 0; p < 2; p++)
						if (nv_glob_q || nv_pot_q == p[0])
							setting_q[p][nv_bank_q] <= nv_val_q[p];
				end else begin
					nv_cnt_q <= nv_cnt_q - 24'h000001;
				end
			end
		end
	end
	assign BUSY = busy_q;

	// Settle delay after copy into wiper
	always_ff @(posedge CLK) begin
		if (RST)
			settle_q <= 16'h0000;
		else if (CE) begin
			if (settle_go)
				settle_q <= 16'(SETTLE_CYCLES); // R13
			else if (settle_q != 16'h0000)
				settle_q <= settle_q - 16'h0001;
		end
	end

	// Shown position and one-hot tap decode per pot
	for (genvar p = 0; p < 2; p++) begin : g_pot
		always_ff @(posedge CLK) begin
			if (RST) begin
				shown_q[p] <= SETTING_RESET;
				taps_q[p]  <= 64'h1;
			end else if (CE) begin
				if (settle_q == 16'h0000 && !settle_go)
					shown_q[p] <= wiper_q[p]; // R13
				taps_q[p] <= 64'h1 << shown_q[p]; // R19
			end
		end
	end
	assign WIPER0_TAPS = taps_q[0];
	assign WIPER1_TAPS = taps_q[1];
endmodule // pot_device

//--- pot_master.sv
// Two-wire bus controller with APB command and status registers
module pot_master import pot_pkg::*; (
	// Clock, reset, enable
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Two-wire link
	pot_link_if.host         link
);
	typedef enum logic [3:0] {
		M_IDLE = 4'b0000,
		M_S1   = 4'b0001,
		M_S2   = 4'b0011,
		M_S3   = 4'b0010,
		M_LO   = 4'b0110,
		M_HI   = 4'b0111,
		M_P1   = 4'b0101,
		M_P2   = 4'b0100,
		M_P3   = 4'b1100
	} mstate_t;

	mstate_t     mst_q;
	logic [7:0]  div_q, tx_q, rx_q;
	logic [13:0] cmd_q;
	logic [3:0]  bit_q;
	logic [1:0]  sda_s_q;
	logic        scl_q, oe_q, nack_q;
	logic [31:0] prdata_q;
	logic        err_q;
	logic        busy, tick, mid, take, last, lvl;

	assign busy = (mst_q != M_IDLE);
	assign tick = (div_q == 8'(SCL_HALF - 1));
	assign mid  = (div_q == 8'(SCL_HALF / 2 - 1));
	assign last = cmd_q[CMD_STEP] ? (bit_q == 4'h0) : (bit_q == 4'h8);
	assign take = PSEL & PENABLE & PWRITE & (PADDR == CMD_OFS) & ~err_q;

	// Level of the current bit, master drives low only
	always_comb begin
		if (cmd_q[CMD_STEP])
			lvl = cmd_q[0]; // R17 R18
		else if (cmd_q[CMD_READ])
			lvl = (bit_q == 4'h8) ? ~cmd_q[CMD_MACK] : 1'b1; // R05
		else
			lvl = (bit_q == 4'h8) ? 1'b1 : tx_q[7]; // R05
	end

	// APB answer prepared in the setup cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			prdata_q <= 32'h0;
			err_q    <= 1'b0;
		end else if (CE && PSEL && !PENABLE) begin
			case (PADDR)
			CMD_OFS: begin
				prdata_q <= {18'h0, cmd_q};
				err_q    <= PWRITE & busy;
			end
			STAT_OFS: begin
				prdata_q <= {22'h0, nack_q, busy, rx_q};
				err_q    <= PWRITE;
			end
			default: begin
				prdata_q <= 32'h0;
				err_q    <= 1'b1;
			end
			endcase
		end
	end
	assign PRDATA  = prdata_q;
	assign PSLVERR = err_q;
	assign PREADY  = 1'b1;

	// Sync of the shared data line
	always_ff @(posedge CLK) begin
		if (RST)
			sda_s_q <= 2'h3;
		else if (CE)
			sda_s_q <= {sda_s_q[0], link.sda};
	end

	// Half-period divider
	always_ff @(posedge CLK) begin
		if (RST || (CE && (!busy || tick)))
			div_q <= 8'h00;
		else if (CE)
			div_q <= div_q + 8'h01;
	end

	// Bit sequencer: clock made here, data moved with clock low
	always_ff @(posedge CLK) begin
		if (RST) begin
			mst_q  <= M_IDLE;
			cmd_q  <= 14'h0;
			tx_q   <= 8'h00;
			rx_q   <= 8'h00;
			bit_q  <= 4'h0;
			scl_q  <= 1'b1;
			oe_q   <= 1'b0;
			nack_q <= 1'b0;
		end else if (CE) begin
			case (mst_q)
			M_IDLE: begin
				if (take) begin
					cmd_q <= PWDATA[13:0]; // R20
					tx_q  <= PWDATA[7:0];
					bit_q <= 4'h0;
					if (PWDATA[CMD_START]) begin
						mst_q <= M_S1;
						scl_q <= 1'b0;
						oe_q  <= 1'b0;
					end else if (!PWDATA[CMD_SKIP]) begin
						mst_q <= M_LO;
						scl_q <= 1'b0; // R02
					end else if (PWDATA[CMD_STOP]) begin
						mst_q <= M_P1;
						scl_q <= 1'b0; // R02
					end
				end
			end
			M_S1: if (tick) begin
				scl_q <= 1'b1;
				mst_q <= M_S2;
			end
			M_S2: if (tick) begin
				oe_q  <= 1'b1; // R03
				mst_q <= M_S3;
			end
			M_S3: if (tick) begin
				scl_q <= 1'b0;
				if (!cmd_q[CMD_SKIP])
					mst_q <= M_LO;
				else
					mst_q <= cmd_q[CMD_STOP] ? M_P1 : M_IDLE;
			end
			M_LO: begin
				if (mid)
					oe_q <= ~lvl; // R02
				if (tick) begin
					scl_q <= 1'b1;
					mst_q <= M_HI;
				end
			end
			M_HI: if (tick) begin
				scl_q <= 1'b0;
				bit_q <= bit_q + 4'h1;
				tx_q  <= {tx_q[6:0], 1'b0};
				if (cmd_q[CMD_READ] && bit_q < 4'h8)
					rx_q <= {rx_q[6:0], sda_s_q[1]};
				if (!cmd_q[CMD_READ] && !cmd_q[CMD_STEP] && last)
					nack_q <= sda_s_q[1]; // R06 R10
				if (last)
					mst_q <= cmd_q[CMD_STOP] ? M_P1 : M_IDLE;
				else
					mst_q <= M_LO;
			end
			M_P1: begin
				if (mid)
					oe_q <= 1'b1;
				if (tick) begin
					scl_q <= 1'b1;
					mst_q <= M_P2;
				end
			end
			M_P2: if (tick) begin
				oe_q  <= 1'b0; // R04
				mst_q <= M_P3;
			end
			M_P3: if (tick)
				mst_q <= M_IDLE;
			default: mst_q <= M_IDLE;
			endcase
		end
	end
	assign link.scl      = scl_q;
	assign link.sda_m_o  = 1'b0;
	assign link.sda_m_oe = oe_q;
endmodule // pot_master

//--- pot_link_chk.sv
// Protocol checker for the two-wire potentiometer link
module pot_link_chk (
	// Clock and reset
	input wire logic	CLK,
	input wire logic	RST,
	// Link signals
	input wire logic	scl,
	input wire logic	sda_m_o,
	input wire logic	sda_m_oe,
	input wire logic	sda_d_o,
	input wire logic	sda_d_oe,
	input wire logic	sda
);
	logic	go_q;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// Frame tracking between start and stop
	always_ff @(posedge CLK) begin
		if (RST)
			go_q <= 1'b0;
		else if (scl && $past(scl) && $fell(sda))
			go_q <= 1'b1;
		else if (scl && $past(scl) && $rose(sda))
			go_q <= 1'b0;
	end
	dev_sda_a: assert property ($changed(sda_d_oe) |-> !scl)
		else $error("device data moved while clock high");
	host_sda_a: assert property (
		$changed(sda_m_oe) && scl |-> $past(scl))
		else $error("host data moved at clock rise");
	dev_start_a: assert property (sda_d_oe |-> go_q)
		else $error("device drove outside a frame");
	turn_take_a: assert property ($rose(sda_d_oe) |-> !sda_m_oe)
		else $error("device drove while host held data");
	one_drv_a: assert property (scl |-> !(sda_m_oe && sda_d_oe))
		else $error("both ends drive with clock high");
	ack_hold_a: assert property ($rose(sda_d_oe) |-> sda_d_oe[*6])
		else $error("device low bit too short");
	scl_high_a: assert property ($rose(scl) |-> scl[*4])
		else $error("clock high half too short");
	scl_low_a: assert property ($fell(scl) |-> !scl[*4])
		else $error("clock low half too short");
	// Main scenarios
	start_c: cover property (scl && $past(scl) && $fell(sda));
	stop_c: cover property (scl && $past(scl) && $rose(sda));
	ack_c: cover property ($rose(sda_d_oe));
endmodule // pot_link_chk

//--- testbench.sv
// Bench: controller and potentiometer device joined over the link
module testbench import pot_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [13:0]	ST = 14'h0100;
	localparam logic [13:0]	SP = 14'h0200;
	localparam logic [13:0]	RD = 14'h0400;
	localparam logic [13:0]	STEP = 14'h1000;
	localparam logic [13:0]	SKIP = 14'h2000;
	localparam logic [3:0]	BRD = 4'h9;
	localparam logic [13:0]	ADR = ST | {6'h00, DEV_TYPE, BRD};
	logic		CLK, RST, PSEL, PENABLE, PWRITE, PREADY;
	logic		PSLVERR, WP_N, BUSY, err;
	logic [11:0]	PADDR;
	logic [31:0]	PWDATA, PRDATA, s;
	logic [63:0]	W0, W1;
	int		failures, total_checks;
	pot_link_if pot_link_if_inst ();
	pot_master pot_master_inst (.CLK(CLK), .RST(RST), .CE(1'b1),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .link(pot_link_if_inst.host));
	pot_device #(.NV_CYCLES(400)) pot_device_inst (.CLK(CLK), .RST(RST),
		.CE(1'b1), .BOARD_SEL(BRD), .WP_N(WP_N),
		.link(pot_link_if_inst.dev), .WIPER0_TAPS(W0), .WIPER1_TAPS(W1),
		.BUSY(BUSY));
	pot_link_chk pot_link_chk_inst (.CLK(CLK), .RST(RST),
		.scl(pot_link_if_inst.scl), .sda_m_o(pot_link_if_inst.sda_m_o),
		.sda_m_oe(pot_link_if_inst.sda_m_oe),
		.sda_d_o(pot_link_if_inst.sda_d_o),
		.sda_d_oe(pot_link_if_inst.sda_d_oe), .sda(pot_link_if_inst.sda));
	// 25 MHz clock
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	task automatic chk(input string n, input logic [63:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tmo();
		failures++;
		end_of_test();
	endtask
	// One APB transfer, one idle edge before it
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		if (n >= 50)
			tmo();
		r = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// Command the controller and wait until it is done
	task automatic xfer(input logic [13:0] c);
		int n;
		apb(1'b1, CMD_OFS, {18'h0, c}, s);
		n = 0;
		do begin
			apb(1'b0, STAT_OFS, 32'h0, s);
			n++;
		end while (s[STAT_BUSY] !== 1'b0 && n < 200);
		if (n >= 200)
			tmo();
		// Let the taps catch up with the link
		repeat (8) @(posedge CLK);
	endtask
	task automatic op(input logic [7:0] ins, input logic [13:0] last);
		xfer(ADR);
		chk("addr ack", s[STAT_NACK], 1'b0);
		xfer({6'h00, ins});
		chk("instr ack", s[STAT_NACK], 1'b0);
		xfer(last);
	endtask
	task automatic idle();
		int n;
		repeat (10) @(posedge CLK);
		n = 0;
		while (BUSY !== 1'b0 && n < 2000) begin
			@(posedge CLK);
			n++;
		end
		if (n >= 2000)
			tmo();
	endtask
	task automatic t_power();
		repeat (4) @(posedge CLK);
		chk("pot0 tap", W0, 64'h1);
		chk("pot1 tap", W1, 64'h1);
		xfer(STEP | 14'h0001);
		chk("no start", W1, 64'h1);
	endtask
	task automatic t_addr();
		xfer(ST | {6'h00, ~DEV_TYPE, BRD});
		chk("type nack", s[STAT_NACK], 1'b1);
		xfer(ST | {6'h00, DEV_TYPE, ~BRD});
		chk("board nack", s[STAT_NACK], 1'b1);
		xfer(ADR);
		xfer(14'h00a3);
		chk("bit1 nack", s[STAT_NACK], 1'b1);
		xfer(SP | SKIP);
	endtask
	task automatic t_wiper();
		op(8'ha1, SP | 14'h002a);
		chk("data ack", s[STAT_NACK], 1'b0);
		chk("pot1 taps", W1, 64'h1 << 42);
		chk("pot0 taps", W0, 64'h1);
		op(8'h91, SP | RD);
		chk("read wiper", s[7:0], 8'h2a);
	endtask
	task automatic t_nv();
		op(8'hc8, SP | 14'h0015);
		xfer(ADR);
		chk("busy nack", s[STAT_NACK], 1'b1);
		chk("busy", BUSY, 1'b1);
		xfer(SP | SKIP);
		idle();
		xfer(ADR);
		chk("poll ack", s[STAT_NACK], 1'b0);
		xfer(SP | SKIP);
		op(8'hb8, SP | RD);
		chk("read setting", s[7:0], 8'h15);
		op(8'hd8, SP | SKIP);
		chk("settling", W0, 64'h1);
		repeat (SETTLE_CYCLES + 20) @(posedge CLK);
		chk("copied", W0, 64'h1 << 21);
	endtask
	task automatic t_copy();
		op(8'h84, SP | SKIP);
		idle();
		op(8'ha0, SP | 14'h0003);
		op(8'ha1, SP | 14'h0004);
		chk("moved", W0, 64'h1 << 3);
		op(8'h14, SP | SKIP);
		repeat (SETTLE_CYCLES + 20) @(posedge CLK);
		chk("global pot0", W0, 64'h1 << 21);
		chk("global pot1", W1, 64'h1 << 42);
	endtask
	task automatic sat(input logic [13:0] v, lvl, input logic [63:0] e);
		op(8'ha1, SP | v);
		xfer(ADR);
		xfer(14'h0021);
		xfer(STEP | lvl);
		chk("saturate", W1, e);
		xfer(SP | SKIP);
	endtask
	task automatic t_step();
		xfer(ADR);
		xfer(14'h0021);
		chk("step ack", s[STAT_NACK], 1'b0);
		repeat (3) xfer(STEP | 14'h0001);
		chk("up", W1, 64'h1 << 45);
		repeat (2) xfer(STEP);
		chk("down", W1, 64'h1 << 43);
		xfer(SP | SKIP);
		xfer(STEP | 14'h0001);
		chk("after stop", W1, 64'h1 << 43);
		sat(14'h003f, 14'h0001, 64'h1 << 63);
		sat(14'h0000, 14'h0000, 64'h1);
	endtask
	task automatic t_wp();
		WP_N <= 1'b0;
		op(8'hec, SP | SKIP);
		repeat (10) @(posedge CLK);
		chk("protected", BUSY, 1'b0);
		op(8'hbc, SP | RD);
		chk("kept", s[7:0], 8'h00);
		WP_N <= 1'b1;
		op(8'hec, SP | SKIP);
		idle();
		op(8'hbc, SP | RD);
		chk("stored", s[7:0], 8'h15);
	endtask
	task automatic t_apb();
		apb(1'b0, 12'h008, 32'h0, s);
		chk("unmapped err", err, 1'b1);
		chk("unmapped data", s, 32'h0);
	endtask
	// Main sequence
	initial begin
		failures = 0;
		total_checks = 0;
		RST = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		WP_N = 1'b1;
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		t_power();
		t_addr();
		t_wiper();
		t_nv();
		t_copy();
		t_step();
		t_wp();
		t_apb();
		end_of_test();
	end
endmodule // testbench
